// ==== hw/lfcsc_defs.vh ====
/*
 * Constants for the low-power clock source and calibration controller.
 * Assumes inclusion by bare name from the design file.
 */
`ifndef LFCSC_DEFS_VH
`define LFCSC_DEFS_VH
// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define LFCSC_OFF_CMD      12'h000
`define LFCSC_OFF_SETTING  12'h004
`define LFCSC_OFF_STATUS   12'h008
`define LFCSC_OFF_CONTROL  12'h00c
`define LFCSC_OFF_UART     12'h010
// ----------------------------------------
// Command word fields
// ----------------------------------------
`define LFCSC_CMD_SRC_LSB  0
`define LFCSC_CMD_V1_LSB   8
`define LFCSC_CMD_V2_LSB   16
`define LFCSC_CMD_HAS_V1   24
`define LFCSC_CMD_HAS_V2   25
`define LFCSC_CMD_QUERY    26
`define LFCSC_CMD_PROD     27
// ----------------------------------------
// Source codes and defaults
// ----------------------------------------
`define LFCSC_SRC_RC       2'h0
`define LFCSC_SRC_XTAL     2'h1
`define LFCSC_SRC_BAD      2'h2
`define LFCSC_SRC_EXT      2'h3
`define LFCSC_PERIOD_MIN   6'h01
`define LFCSC_PERIOD_MAX   6'h20
`define LFCSC_PERIOD_DEF   6'h10
`define LFCSC_ACC_MAX      6'h0b
`define LFCSC_ACC_DEF      6'h07
`define LFCSC_TEMP_INVALID 6'h01
`define LFCSC_TEMP_MAX     6'h20
`define LFCSC_TEMP_DEF     6'h02
// ----------------------------------------
// Response codes and link defaults
// ----------------------------------------
`define LFCSC_RSP_NONE     2'h0
`define LFCSC_RSP_OK       2'h1
`define LFCSC_RSP_ERROR    2'h2
`define LFCSC_BAUD_DEF     32'h0001c200
`define LFCSC_FRAME_DEF    32'h00000103
`define LFCSC_QUARTER_LF   32'h00002000
`endif

// ==== hw/lfcsc_ctrl.v ====
/*
 * Low-power clock source selection and internal oscillator calibration scheduler with APB registers.
 * Assumes a 100 MHz pclk, a synchronous 32.768 kHz tick input and an external text parser that turns
 * host commands into command-register writes.
 */
// The APB slave port and the placing of the registers were decided locally.
// Notes on behaviour
// RULE1: source 0 oscillator, 1 crystal, 3 clock; auto
// RULE2: check period in quarter seconds, 1..32, default 16
// RULE3: crystal accuracy code 0..11, default 7
// RULE4: temperature setting 0 calibrates every period
// RULE5: host never writes temperature setting 1
// RULE6: setting N: calibrate on change, force every N
// RULE7: temperature setting defaults to 2
// RULE8: host keeps calibration within every 8 seconds
// RULE9: host keeps drift below half degree
// RULE10: set answers OK, query returns values, fail ERROR
// RULE11: serial port defaults 115200 8N1 flow control
// RULE12: host ties clear-to-send low in two-wire use
// RULE13: data-set-ready selects command, connect, enable, sleep
// RULE14: settings writable once, cleared only by erase
// RULE15: command accepted only in production mode
// RULE16: out-of-range parameter answers ERROR, nothing stored
// RULE17: quarter second counted as 8192 low-power cycles
`include "lfcsc_defs.vh"
module lfcsc_ctrl #(
    parameter QUARTER_CYCLES = `LFCSC_QUARTER_LF
) (
    // APB clock and reset
    input  wire        pclk,
    input  wire        presetn,
    // APB slave
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [11:0] paddr,
    input  wire [31:0] pwdata,
    output reg  [31:0] prdata,
    output reg         pready,
    output reg         pslverr,
    // Low-power clock tick, temperature and erase
    input  wire        lf_tick,
    input  wire        temp_changed,
    input  wire        nvm_erase,
    input  wire        dsr,
    // Calibration and mode outputs
    output reg         cal_start,
    output reg         temp_measure,
    output reg  [1:0]  dsr_action
);

    // ----------------------------------------
    // Stored settings
    // ----------------------------------------
    reg        written;
    reg [1:0]  source;
    reg [5:0]  value1;
    reg [5:0]  value2;
    reg        prod_mode;
    reg [1:0]  response;
    reg [1:0]  dsr_mode;
    reg [31:0] uart_baud;
    reg [31:0] uart_frame;
    reg [12:0] lf_count;
    reg [5:0]  period_count;
    reg [5:0]  force_count;

    wire       wr_en = psel & penable & pwrite;
    wire       cmd_wr = wr_en & (paddr == `LFCSC_OFF_CMD);
    wire [1:0] c_src = pwdata[`LFCSC_CMD_SRC_LSB +: 2];
    wire [5:0] c_v1 = pwdata[`LFCSC_CMD_V1_LSB +: 6];
    wire [5:0] c_v2 = pwdata[`LFCSC_CMD_V2_LSB +: 6];
    wire       c_h1 = pwdata[`LFCSC_CMD_HAS_V1];
    wire       c_h2 = pwdata[`LFCSC_CMD_HAS_V2];
    wire       c_query = pwdata[`LFCSC_CMD_QUERY];
    wire       c_prod = pwdata[`LFCSC_CMD_PROD];

    // ----------------------------------------
    // Command validation
    // ----------------------------------------
    reg       cmd_ok;
    reg [5:0] next_v1;
    reg [5:0] next_v2;
    always @* begin
        cmd_ok = 1'b1;
        next_v1 = 6'h00;
        next_v2 = 6'h00;
        case (c_src)
            `LFCSC_SRC_RC: begin
                next_v1 = c_h1 ? c_v1 : `LFCSC_PERIOD_DEF; // RULE2
                next_v2 = c_h2 ? c_v2 : `LFCSC_TEMP_DEF; // RULE7
                if (next_v1 < `LFCSC_PERIOD_MIN || next_v1 > `LFCSC_PERIOD_MAX)
                    cmd_ok = 1'b0; // RULE16
                if (next_v2 == `LFCSC_TEMP_INVALID || next_v2 > `LFCSC_TEMP_MAX)
                    cmd_ok = 1'b0; // RULE16
            end
            `LFCSC_SRC_XTAL: begin
                next_v1 = c_h1 ? c_v1 : `LFCSC_ACC_DEF; // RULE3
                if (next_v1 > `LFCSC_ACC_MAX || c_h2)
                    cmd_ok = 1'b0; // RULE16
            end
            `LFCSC_SRC_EXT: begin
                if (c_h1 || c_h2)
                    cmd_ok = 1'b0;
            end
            default: cmd_ok = 1'b0; // RULE16
        endcase
        if (!prod_mode || written)
            cmd_ok = 1'b0; // RULE15 RULE14
    end

    // ----------------------------------------
    // Stored settings in the one-time area
    // ----------------------------------------
    // These model nonvolatile cells: presetn leaves them alone, so a reset restarts with the new
    // settings, and only nvm_erase blanks them; they hold no defined value until the first erase.
    // A command in the same cycle as an erase lands only if the area was already blank, as cmd_ok sees the old written bit; its assignment comes last.
    always @(posedge pclk) begin
        if (nvm_erase) begin
            written <= 1'b0; // RULE14
            source  <= `LFCSC_SRC_BAD;
            value1  <= 6'h00;
            value2  <= 6'h00;
        end
        if (cmd_wr && !c_prod && !c_query && cmd_ok) begin
            written <= 1'b1; // RULE14
            source  <= c_src; // RULE1
            value1  <= next_v1;
            value2  <= next_v2;
        end
    end

    // ----------------------------------------
    // Register writes and command handling
    // ----------------------------------------
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prod_mode  <= 1'b0; // RULE15
            response   <= `LFCSC_RSP_NONE;
            dsr_mode   <= 2'h0;
            uart_baud  <= `LFCSC_BAUD_DEF;
            uart_frame <= `LFCSC_FRAME_DEF;
        end else begin
            if (cmd_wr) begin
                if (c_prod) begin
                    prod_mode <= 1'b1; // RULE15
                    response  <= `LFCSC_RSP_OK;
                end else if (c_query || cmd_ok) begin
                    response <= `LFCSC_RSP_OK; // RULE10
                end else begin
                    response <= `LFCSC_RSP_ERROR; // RULE10
                end
            end
            if (wr_en && paddr == `LFCSC_OFF_CONTROL)
                dsr_mode <= pwdata[1:0];
            if (wr_en && paddr == `LFCSC_OFF_UART)
                uart_baud <= pwdata; // RULE11
        end
    end

    // ----------------------------------------
    // APB read and answer
    // ----------------------------------------
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata  <= 32'h00000000;
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready  <= psel & ~penable;
            pslverr <= 1'b0;
            prdata  <= 32'h00000000;
            if (psel && !penable) begin
                case (paddr)
                    `LFCSC_OFF_CMD:     prdata <= 32'h00000000;
                    `LFCSC_OFF_SETTING: prdata <= {8'h00, 2'h0, value2, 2'h0, value1, 5'h00, written, source};
                    `LFCSC_OFF_STATUS:  prdata <= {28'h0000000, prod_mode, written, response};
                    `LFCSC_OFF_CONTROL: prdata <= {30'h00000000, dsr_mode};
                    `LFCSC_OFF_UART:    prdata <= uart_baud | (uart_frame << 24);
                    default:            pslverr <= 1'b1;
                endcase
            end
        end
    end

    // ----------------------------------------
    // Calibration scheduler on low-power ticks
    // ----------------------------------------
    wire rc_active = written && source == `LFCSC_SRC_RC;
    wire quarter_end = lf_tick && lf_count == QUARTER_CYCLES - 1;
    wire period_end = quarter_end && period_count >= value1 - 6'h01;
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            lf_count     <= 13'h0000;
            period_count <= 6'h00;
            force_count  <= 6'h00;
            cal_start    <= 1'b0;
            temp_measure <= 1'b0;
            dsr_action   <= 2'h0;
        end else begin
            cal_start    <= 1'b0;
            temp_measure <= 1'b0;
            dsr_action   <= dsr ? dsr_mode : 2'h0; // RULE13
            if (!rc_active) begin
                lf_count     <= 13'h0000;
                period_count <= 6'h00;
                force_count  <= 6'h00;
            end else if (lf_tick) begin
                lf_count <= quarter_end ? 13'h0000 : lf_count + 13'h0001; // RULE17
                if (quarter_end)
                    period_count <= period_end ? 6'h00 : period_count + 6'h01; // RULE2
                if (period_end) begin
                    if (value2 == 6'h00) begin
                        cal_start <= 1'b1; // RULE4
                    end else begin
                        temp_measure <= 1'b1; // RULE6
                        if (temp_changed || force_count >= value2 - 6'h01) begin
                            cal_start   <= 1'b1; // RULE6
                            force_count <= 6'h00;
                        end else begin
                            force_count <= force_count + 6'h01;
                        end
                    end
                end
            end
        end
    end

endmodule

// ==== bench/lfcsc_lf_model.sv ====
/* Low-power clock tick source for the controller.
   Assumes one pclk domain; a tick stands for one low-power clock edge. */
module lfcsc_lf_model #(
    parameter DIV = 4
) (
    // Clock and reset
    input  wire  pclk,
    input  wire  presetn,
    // Tick output
    output logic lf_tick
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [7:0] cnt;
    // One pclk pulse every DIV cycles.
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt     <= 8'h00;
            lf_tick <= 1'b0;
        end else begin
            cnt     <= (cnt == DIV - 1) ? 8'h00 : cnt + 8'h01;
            lf_tick <= (cnt == DIV - 1);
        end
    end
endmodule

// ==== bench/lfcsc_ctrl_checker.sv ====
/* Port assertions for lfcsc_ctrl.
   Assumes it is bound to every lfcsc_ctrl instance. */
module lfcsc_ctrl_checker #(
    parameter QUARTER_CYCLES = 8192
) (
    input wire        pclk,
    input wire        presetn,
    input wire        psel,
    input wire        penable,
    input wire [11:0] paddr,
    input wire        pready,
    input wire        pslverr,
    input wire        dsr,
    input wire [1:0]  dsr_action,
    input wire        cal_start,
    input wire        temp_measure
);
    timeunit 1ns;
    timeprecision 100ps;
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    chk_zero_wait: assert property (psel && !penable |=> pready) else $error("no pready after setup");
    chk_ready_access: assert property (pready |-> psel && penable) else $error("pready outside access");
    chk_ready_single: assert property (pready |=> !pready) else $error("pready too long");
    chk_err_unmapped: assert property (pready && paddr > 12'h010 |-> pslverr) else $error("no error");
    chk_ok_mapped: assert property (pready && paddr <= 12'h010 && paddr[1:0] == 2'h0 |-> !pslverr)
        else $error("spurious error");
    chk_dsr_idle: assert property (!dsr |=> dsr_action == 2'h0) else $error("dsr action while low");
    chk_cal_gap: assert property (cal_start |=> !cal_start [*3]) else $error("calibration too close");
    chk_meas_gap: assert property ($rose(temp_measure) |=> !temp_measure [*3]) else $error("measure burst");
endmodule
bind lfcsc_ctrl lfcsc_ctrl_checker #(.QUARTER_CYCLES(QUARTER_CYCLES)) u_chk (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .paddr(paddr), .pready(pready), .pslverr(pslverr), .dsr(dsr),
    .dsr_action(dsr_action), .cal_start(cal_start), .temp_measure(temp_measure));

// ==== bench/lfcsc_ctrl_tb_top.sv ====
/* Self-checking bench for lfcsc_ctrl over APB.
   Assumes the tick model and a shortened quarter count of 4 ticks. */
module lfcsc_ctrl_tb_top;
    timeunit 1ns;
    timeprecision 100ps;
    logic        pclk, presetn, psel, penable, pwrite, temp_changed, nvm_erase, dsr, rerr;
    logic [11:0] paddr;
    logic [31:0] pwdata, rdata;
    wire  [31:0] prdata;
    wire         pready, pslverr, lf_tick, cal_start, temp_measure;
    wire  [1:0]  dsr_action;
    int          num_errors = 0, checked = 0, ncal = 0, nmeas = 0, cycles = 0, c0, m0;
    localparam logic [31:0] PROD = 32'h08000000;
    localparam logic [31:0] BAD [0:6] = '{32'h2, 32'h01002100, 32'h01000c01, 32'h01000000, 32'h03211000,
        32'h03011000, 32'h01000103};
    lfcsc_ctrl #(.QUARTER_CYCLES(4)) dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .lf_tick(lf_tick), .temp_changed(temp_changed), .nvm_erase(nvm_erase), .dsr(dsr),
        .cal_start(cal_start), .temp_measure(temp_measure), .dsr_action(dsr_action));
    lfcsc_lf_model #(.DIV(4)) u_lf (.pclk(pclk), .presetn(presetn), .lf_tick(lf_tick));
    initial begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end
    // Pulses are counted on the falling edge, away from the bench's own edge.
    always @(negedge pclk) begin
        ncal += cal_start;
        nmeas += temp_measure;
    end
    always @(posedge pclk) begin
        if (++cycles == 10000) begin
            num_errors++;
            conclude();
        end
    end
    task chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
        checked++;
        if (seen !== exp) begin
            num_errors++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        // Wait however long the answer takes; only the bench timeout ends a hang.
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rdata = prdata;
        rerr  = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask
    task rd_chk(input logic [11:0] a, input logic [31:0] m, input logic [31:0] e, input string what);
        apb(1'b0, a, 32'h0);
        chk(rdata & m, e, what);
    endtask
    task erase_set(input logic [31:0] d);
        nvm_erase <= 1'b1;
        @(posedge pclk);
        nvm_erase <= 1'b0;
        apb(1'b1, 12'h000, PROD);
        apb(1'b1, 12'h000, d);
    endtask
    task count(input int len, input int ec, input int em);
        repeat (100) @(posedge pclk);
        c0 = ncal;
        m0 = nmeas;
        repeat (len) @(posedge pclk);
        chk(ncal - c0, ec, "calibrations");
        if (em >= 0) chk(nmeas - m0, em, "measurements");
    endtask
    task conclude;
        if (num_errors == 0 && checked > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    initial begin
        // The controller has no clear-to-send pin; the host board keeps it low, as in two-wire use.
        {psel, penable, pwrite, paddr, pwdata, temp_changed, dsr, presetn} = '0;
        // The one-time area is blank only after an erase, so erase it while reset is held.
        nvm_erase = 1'b1;
        repeat (5) @(posedge pclk);
        presetn   <= 1'b1;
        nvm_erase <= 1'b0;
        rd_chk(12'h010, 32'hffffffff, 32'h0301c200, "uart defaults");
        rd_chk(12'h004, 32'h7, 32'h2, "auto source");
        apb(1'b1, 12'h000, 32'h1);
        rd_chk(12'h008, 32'h3, 32'h2, "set outside production");
        apb(1'b1, 12'h000, PROD);
        foreach (BAD[i]) begin
            apb(1'b1, 12'h000, BAD[i]);
            rd_chk(12'h008, 32'h3, 32'h2, "bad parameter");
            rd_chk(12'h004, 32'h4, 32'h0, "bad not stored");
        end
        apb(1'b1, 12'h000, 32'h1);
        rd_chk(12'h008, 32'h3, 32'h1, "set answer");
        rd_chk(12'h004, 32'h3f07, 32'h0705, "crystal default");
        apb(1'b1, 12'h000, 32'h3);
        rd_chk(12'h008, 32'h3, 32'h2, "second set");
        rd_chk(12'h004, 32'h3f07, 32'h0705, "kept setting");
        // A reset in mid-run leaves production mode but keeps the stored setting.
        @(posedge pclk);
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        rd_chk(12'h008, 32'hf, 32'h4, "status after reset");
        rd_chk(12'h004, 32'h3f07, 32'h0705, "setting after reset");
        apb(1'b1, 12'h000, 32'h04000000);
        rd_chk(12'h008, 32'h3, 32'h1, "query answer");
        apb(1'b0, 12'h014, 32'h0);
        chk({31'h0, rerr}, 32'h1, "unmapped error");
        apb(1'b1, 12'h00c, 32'h2);
        dsr <= 1'b1;
        repeat (3) @(posedge pclk);
        chk({30'h0, dsr_action}, 32'h2, "dsr action");
        dsr <= 1'b0;
        erase_set(32'h03000100);
        count(160, 10, -1);
        // Defaults keep calibration within 8 s and avoid the invalid code.
        erase_set(32'h0);
        rd_chk(12'h004, 32'h3f3f07, 32'h021004, "internal defaults");
        count(1024, 2, 4);
        temp_changed <= 1'b1;
        count(1024, 4, 4);
        erase_set(32'h3);
        rd_chk(12'h004, 32'h3f3f07, 32'h7, "external clock");
        count(256, 0, 0);
        conclude();
    end
endmodule
